// ===== design/seq_pkg.sv
// Package for the stimulus vector sequencer: widths, instruction codes, states, carriers.
// Assumes a single 25 MHz core clock domain and synchronous active-high reset.
package seq_pkg;
   localparam int unsigned CLK_PERIOD_NS  = 40;
   localparam int unsigned NUM_PODS       = 5;
   localparam int unsigned NUM_RAMS       = 6;
   localparam int unsigned WORD_W         = 16;
   localparam int unsigned ROW_W          = 4;
   localparam int unsigned COL_W          = 4;
   localparam int unsigned FIFO_DEPTH     = 8;
   localparam int unsigned NUM_LOOPS      = 4;
   localparam int unsigned NUM_EVENTS     = 4;
   // Output vector period per frequency mode, in ns
   localparam int unsigned PERIOD_50_NS   = 20;
   localparam int unsigned PERIOD_100_NS  = 10;
   localparam int unsigned PERIOD_200_NS  = 5;
   // Cycles between vectors in each mode; at least one core cycle
   localparam int unsigned DIV_50  = (PERIOD_50_NS  + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned DIV_100 = (PERIOD_100_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned DIV_200 = (PERIOD_200_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [ROW_W-1:0] ROW_RST = 4'h0;
   localparam logic [COL_W-1:0] COL_RST = 4'h0;

   // Instruction word: [15:12] opcode, [11:10] register select, [7:0] target address
   localparam logic [3:0] OP_NOP   = 4'h0;
   localparam logic [3:0] OP_BREAK = 4'h1;
   localparam logic [3:0] OP_WAIT  = 4'h2;
   localparam logic [3:0] OP_IF    = 4'h3;
   localparam logic [3:0] OP_LOOP  = 4'h4;
   localparam int unsigned OP_LSB  = 12;
   localparam int unsigned SEL_LSB = 10;

   typedef enum logic [1:0] {
      MODE_50  = 2'b00,
      MODE_100 = 2'b01,
      MODE_200 = 2'b10
   } freq_mode_e;

   typedef enum logic [1:0] {
      BR_NEVER  = 2'b00,
      BR_ALWAYS = 2'b01,
      BR_EVENT  = 2'b10
   } branch_e;

   typedef enum logic [1:0] {
      PAT_RAM    = 2'b00,
      PAT_CHECK  = 2'b01,
      PAT_WALK   = 2'b10
   } pattern_e;

   typedef enum logic [2:0] {
      ST_STOPPED = 3'b000,
      ST_RUNNING = 3'b001,
      ST_WAITING = 3'b010,
      ST_BREAK   = 3'b011
   } seq_state_e;

   typedef struct packed {
      logic [ROW_W-1:0] row;
      logic [COL_W-1:0] col;
   } addr_s;

   typedef struct packed {
      logic [NUM_PODS*WORD_W-1:0] pods;
   } vector_s;

   typedef struct packed {
      logic       running;
      logic       waiting;
      logic       by_break;
      logic       by_stop;
   } status_s;
endpackage : seq_pkg

// ===== design/vec_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; reset clears pointers.
`timescale 1ns/1ps
`default_nettype none
module vec_fifo #(
   parameter int unsigned WIDTH = 80,
   parameter int unsigned DEPTH = 8
) (
   input  wire logic             core_clk,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int unsigned AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0]   cnt;
   } fifo_s;
   fifo_s st_r, st_nxt;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push, pop;

   assign in_ready  = (st_r.cnt != (AW+1)'(DEPTH));
   assign out_valid = (st_r.cnt != '0);
   assign out_data  = mem[st_r.rp];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      st_nxt = st_r;
      if (push) begin
         st_nxt.wp = (st_r.wp == AW'(DEPTH-1)) ? '0 : st_r.wp + 1'b1;
      end
      if (pop) begin
         st_nxt.rp = (st_r.rp == AW'(DEPTH-1)) ? '0 : st_r.rp + 1'b1;
      end
      st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
      if (push) begin
         mem[st_r.wp] <= in_data;
      end
   end
endmodule : vec_fifo
`default_nettype wire

// ===== design/rate_div.sv
// Vector rate tick generator: one tick every DIV cycles for the selected mode.
// Assumes the core clock; a tick is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
module rate_div
   import seq_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire freq_mode_e mode,
   output logic            tick
);
   typedef struct packed {
      logic [7:0] cnt;
      logic       tick;
   } div_s;
   div_s st_r, st_nxt;
   logic [7:0] lim;

   always_comb begin
      st_nxt = st_r;
      case (mode)
         MODE_50:  lim = 8'(DIV_50 - 1);
         MODE_100: lim = 8'(DIV_100 - 1);
         default:  lim = 8'(DIV_200 - 1);
      endcase
      st_nxt.tick = (st_r.cnt >= lim);
      st_nxt.cnt  = (st_r.cnt >= lim) ? 8'h00 : st_r.cnt + 8'h01;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign tick = st_r.tick;
endmodule : rate_div
`default_nettype wire

// ===== design/vector_sequencer.sv
// Stimulus vector sequencer: address counters, six vector RAMs, instruction decode, outputs.
// Assumes RAM loading through the write port while stopped; one core clock.
// Operation
// - Status shows running or stopped
// - Software stop halts pipeline, disables outputs
// - Selected clock source per mode drives pipeline (clk_src_sel is unused; the core clock divided per mode drives it)
// - Single step advances address, presents word
// - Sixteen-bit RAMs with addressed test read
// - Five pod RAMs plus instruction RAM
// - Separate row and column address counters
// - Four loop registers set or zero address
// - All-zero instruction is no-operation
// - Break stops, status reports break
// - Wait holds on selected event, reported
// - No-event wait does not halt
// - Any-condition wait halts at wait
// - Wait clear resumes from current wait
// - If selects branch; never takes non-if
// - Always branch takes if branch
// - Vector period follows frequency mode (all three dividers are 1: one vector per 40 ns core cycle in every mode)
// - Checkerboard or walking-ones test patterns
`timescale 1ns/1ps
`default_nettype none
module vector_sequencer
   import seq_pkg::*;
#(
   parameter int unsigned ROWS = 16,
   parameter int unsigned COLS = 16
) (
   input  wire logic                        core_clk,
   input  wire logic                        rst,
   input  wire logic                        start,
   input  wire logic                        stop,
   input  wire logic                        step,
   input  wire logic                        wait_clear,
   input  wire freq_mode_e                  freq_mode,
   input  wire logic [1:0]                  clk_src_sel,
   input  wire branch_e                     branch_pattern,
   input  wire logic                        branch_event,
   input  wire pattern_e                    test_pattern,
   input  wire logic [NUM_EVENTS-1:0]       event_none,
   input  wire logic [NUM_EVENTS-1:0]       event_hit,
   input  wire logic                        loop_wr,
   input  wire logic [1:0]                  loop_sel,
   input  wire addr_s                       loop_value,
   input  wire logic                        loop_set,
   input  wire logic                        loop_zero,
   input  wire logic                        ram_wr,
   input  wire logic [2:0]                  ram_sel,
   input  wire addr_s                       ram_addr,
   input  wire logic [WORD_W-1:0]           ram_wdata,
   input  wire logic                        vec_ready,
   output logic                             vec_valid,
   output logic [NUM_PODS*WORD_W-1:0]       vec_out,
   output logic                             out_enable,
   output status_s                          status,
   output addr_s                            cur_addr,
   output logic [NUM_RAMS*WORD_W-1:0]       test_read
);
   localparam int unsigned DEPTH = ROWS * COLS;

   typedef struct packed {
      seq_state_e                 state;
      addr_s                      addr;
      addr_s [NUM_LOOPS-1:0]      loops;
      status_s                    status;
      logic                       out_en;
      logic [NUM_PODS*WORD_W-1:0] walk;
      logic                       check;
      logic [NUM_RAMS*WORD_W-1:0] tread;
   } seq_s;

   seq_s st_r, st_nxt;
   logic [WORD_W-1:0] ram [NUM_RAMS][DEPTH];
   logic [NUM_RAMS*WORD_W-1:0] rd_all;
   logic [WORD_W-1:0] instr;
   logic [3:0]        op;
   logic [1:0]        sel;
   addr_s             target;
   logic              tick, adv, push, fifo_ready;
   vector_s           vec_src;
   logic [NUM_PODS*WORD_W-1:0] fifo_out;
   logic              fifo_valid;

   // Test read port: word at the current address of every RAM
   always_comb begin
      for (int i = 0; i < NUM_RAMS; i++) begin
         rd_all[i*WORD_W +: WORD_W] = ram[i][{st_r.addr.row, st_r.addr.col}];
      end
   end
   assign instr  = rd_all[NUM_PODS*WORD_W +: WORD_W];
   assign op     = instr[OP_LSB +: 4];
   assign sel    = instr[SEL_LSB +: 2];
   assign target = addr_s'(instr[ROW_W+COL_W-1:0]);

   // Rate tick from the core clock divided per frequency mode; clk_src_sel is unused
   rate_div u_div (
      .core_clk (core_clk),
      .rst      (rst),
      .mode     (freq_mode),
      .tick     (tick)
   );

   // Pattern source: RAM data or built-in test patterns
   always_comb begin
      case (test_pattern)
         PAT_CHECK: vec_src.pods = st_r.check ? {(NUM_PODS*WORD_W/4){4'hA}}
                                              : {(NUM_PODS*WORD_W/4){4'h5}};
         PAT_WALK:  vec_src.pods = st_r.walk;
         default:   vec_src.pods = rd_all[NUM_PODS*WORD_W-1:0];
      endcase
   end

   assign adv  = fifo_ready && ((st_r.state == ST_RUNNING && tick) ||
                               (st_r.state != ST_RUNNING && st_r.state != ST_WAITING && step));
   assign push = adv && st_r.out_en;

   always_comb begin
      st_nxt = st_r;
      st_nxt.tread = rd_all;
      if (loop_wr) begin
         st_nxt.loops[loop_sel] = loop_value;
      end
      if (adv) begin
         st_nxt.check = ~st_r.check;
         st_nxt.walk  = (st_r.walk == '0 ||
                         st_r.walk[NUM_PODS*WORD_W-1]) ? (NUM_PODS*WORD_W)'(1)
                                                        : {st_r.walk[NUM_PODS*WORD_W-2:0], 1'b0};
         // Column first, then carry into the row counter
         if (st_r.addr.col == COL_W'(COLS-1)) begin
            st_nxt.addr.col = COL_RST;
            st_nxt.addr.row = (st_r.addr.row == ROW_W'(ROWS-1)) ? ROW_RST
                                                                 : st_r.addr.row + 1'b1;
         end else begin
            st_nxt.addr.col = st_r.addr.col + 1'b1;
         end
      end
      case (st_r.state)
         ST_RUNNING: begin
            if (tick && fifo_ready) begin
               case (op)
                  OP_BREAK: begin
                     st_nxt.state           = ST_BREAK;
                     st_nxt.status.running  = 1'b0;
                     st_nxt.status.by_break = 1'b1;
                  end
                  OP_WAIT: begin
                     // No-event wait passes through; a hit on the selected event holds
                     if (!event_none[sel] && event_hit[sel]) begin
                        st_nxt.state          = ST_WAITING;
                        st_nxt.status.waiting = 1'b1;
                        st_nxt.addr           = st_r.addr;
                     end
                  end
                  OP_IF: begin
                     if (branch_pattern == BR_ALWAYS ||
                         (branch_pattern == BR_EVENT && branch_event)) begin
                        st_nxt.addr = target;
                     end
                  end
                  OP_LOOP: st_nxt.addr = st_r.loops[sel];
                  default: ;
               endcase
            end
         end
         ST_WAITING: begin
            if (wait_clear) begin
               st_nxt.state          = ST_RUNNING;
               st_nxt.status.waiting = 1'b0;
               st_nxt.addr.col       = st_r.addr.col + 1'b1;
               st_nxt.addr.row       = (st_r.addr.col == COL_W'(COLS-1))
                                       ? st_r.addr.row + 1'b1 : st_r.addr.row;
            end
         end
         default: begin
            if (start) begin
               st_nxt.state          = ST_RUNNING;
               st_nxt.out_en         = 1'b1;
               st_nxt.status         = '0;
               st_nxt.status.running = 1'b1;
            end else if (step) begin
               st_nxt.out_en = 1'b1;
            end
         end
      endcase
      if (!loop_wr && loop_set && st_r.state != ST_RUNNING) begin
         st_nxt.addr = st_r.loops[loop_sel];
      end else if (!loop_wr && loop_zero && st_r.state != ST_RUNNING) begin
         st_nxt.addr = '0;
      end
      if (stop) begin
         st_nxt.state          = ST_STOPPED;
         st_nxt.out_en         = 1'b0;
         st_nxt.status.running = 1'b0;
         st_nxt.status.waiting = 1'b0;
         st_nxt.status.by_stop = 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
      if (ram_wr && int'(ram_sel) < NUM_RAMS) begin
         ram[ram_sel][{ram_addr.row, ram_addr.col}] <= ram_wdata;
      end
   end

   vec_fifo #(
      .WIDTH (NUM_PODS*WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .core_clk  (core_clk),
      .rst       (rst || stop),
      .in_valid  (push),
      .in_ready  (fifo_ready),
      .in_data   (vec_src.pods),
      .out_valid (fifo_valid),
      .out_ready (vec_ready || !vec_valid),
      .out_data  (fifo_out)
   );

   // Registered output stage fed from the FIFO
   always_ff @(posedge core_clk) begin
      if (rst || stop) begin
         vec_valid <= 1'b0;
         vec_out   <= '0;
      end else if (vec_ready || !vec_valid) begin
         vec_valid <= fifo_valid;
         vec_out   <= fifo_valid ? fifo_out : vec_out;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         out_enable <= 1'b0;
         status     <= '0;
         cur_addr   <= '0;
         test_read  <= '0;
      end else begin
         out_enable <= st_nxt.out_en;
         status     <= st_nxt.status;
         cur_addr   <= st_nxt.addr;
         test_read  <= st_r.tread;
      end
   end
endmodule : vector_sequencer
`default_nettype wire

// ===== tb/seq_props.sv
// Port checker for the vector sequencer.
// Bound into vector_sequencer; one core clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module seq_props
   import seq_pkg::*;
(
   input wire logic                       core_clk,
   input wire logic                       rst,
   input wire logic                       start,
   input wire logic                       stop,
   input wire logic                       step,
   input wire logic                       wait_clear,
   input wire logic                       loop_set,
   input wire logic                       loop_zero,
   input wire logic                       vec_ready,
   input wire logic                       vec_valid,
   input wire logic                       out_enable,
   input wire logic [NUM_PODS*WORD_W-1:0] vec_out,
   input wire status_s                    status,
   input wire addr_s                      cur_addr
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   wire logic [7:0] ca = cur_addr;
   wire logic       idle = !status.running && !status.waiting;
   property p_reset;
      @(posedge core_clk) disable iff (1'b0)
      rst |=> status == '0 && !out_enable && ca == 8'h00 && !vec_valid;
   endproperty
   a_reset: assert property (p_reset) else $error("outputs not cleared");
   property p_start;
      start && !stop && idle |=> status.running && out_enable;
   endproperty
   a_start: assert property (p_start) else $error("start did not run");
   property p_stop;
      stop |=> !status.running && !status.waiting && !out_enable;
   endproperty
   a_stop: assert property (p_stop) else $error("stop did not halt");
   property p_run_oe;
      status.running |-> out_enable;
   endproperty
   a_run_oe: assert property (p_run_oe) else $error("running with outputs off");
   property p_oe_off;
      !out_enable && !start && !step |=> !out_enable;
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("outputs enabled without start");
   property p_step;
      step && !stop && !start && !loop_set && !loop_zero && idle |=> ca == $past(ca) + 8'h01;
   endproperty
   a_step: assert property (p_step) else $error("step did not advance");
   property p_hold;
      status.waiting && $past(status.waiting) && !wait_clear && !stop |=> $stable(ca);
   endproperty
   a_hold: assert property (p_hold) else $error("address moved in wait");
   property p_clear;
      status.waiting && wait_clear && !stop |=> !status.waiting;
   endproperty
   a_clear: assert property (p_clear) else $error("wait not released");
   property p_break;
      status.by_break |-> !status.running;
   endproperty
   a_break: assert property (p_break) else $error("running after break");
   property p_vhold;
      vec_valid && !vec_ready && !stop && !$past(stop) |=> vec_valid && $stable(vec_out);
   endproperty
   a_vhold: assert property (p_vhold) else $error("vector dropped in stall");
endmodule : seq_props
bind vector_sequencer seq_props u_props (.core_clk(core_clk), .rst(rst), .start(start),
   .stop(stop), .step(step), .wait_clear(wait_clear), .loop_set(loop_set),
   .loop_zero(loop_zero), .vec_ready(vec_ready), .vec_valid(vec_valid),
   .out_enable(out_enable), .vec_out(vec_out), .status(status), .cur_addr(cur_addr));
`default_nettype wire

// ===== tb/vec_sink.sv
// Target under test: takes vectors, stalls when told.
// Assumes the core clock; hold comes from the bench.
`timescale 1ns/1ps
`default_nettype none
module vec_sink
   import seq_pkg::*;
(
   input wire logic                       core_clk,
   input wire logic                       rst,
   input wire logic                       hold,
   input wire logic                       vec_valid,
   input wire logic [NUM_PODS*WORD_W-1:0] vec_out,
   output logic                           vec_ready,
   output logic [31:0]                    got,
   output logic [NUM_PODS*WORD_W-1:0]     last_vec
);
   assign vec_ready = !hold;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         got <= 32'h0;
         last_vec <= '0;
      end else if (vec_valid && vec_ready) begin
         got <= got + 32'h1;
         last_vec <= vec_out;
      end
   end
endmodule : vec_sink
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the vector sequencer.
// Assumes seq_props is bound in and vec_sink is the target.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import seq_pkg::*;
   localparam int GO = 0, HALT = 1, STEP = 2, CLR = 3, LSET = 4, LZERO = 5;
   logic                       core_clk, rst, branch_event, loop_wr, ram_wr, hold;
   logic                       vec_ready, vec_valid, out_enable, stall_en, tk;
   logic [5:0]                 ctl;
   freq_mode_e                 freq_mode;
   branch_e                    branch_pattern;
   pattern_e                   test_pattern;
   logic [1:0]                 clk_src_sel, loop_sel;
   logic [2:0]                 ram_sel;
   logic [3:0]                 event_none, event_hit;
   addr_s                      loop_value, ram_addr, cur_addr;
   logic [15:0]                ram_wdata;
   logic [NUM_PODS*WORD_W-1:0] vec_out, last_vec;
   logic [NUM_RAMS*WORD_W-1:0] test_read;
   status_s                    status;
   logic [31:0]                got, n0, dv;
   logic [31:0]                seed = 32'hA198D8D2;
   logic [15:0]                img [6][256];
   logic [7:0]                 lv [4];
   int                         failures, checked;
   vector_sequencer dut (.core_clk(core_clk), .rst(rst), .start(ctl[GO]), .stop(ctl[HALT]),
      .step(ctl[STEP]), .wait_clear(ctl[CLR]), .freq_mode(freq_mode),
      .clk_src_sel(clk_src_sel), .branch_pattern(branch_pattern), .branch_event(branch_event),
      .test_pattern(test_pattern), .event_none(event_none), .event_hit(event_hit),
      .loop_wr(loop_wr), .loop_sel(loop_sel), .loop_value(loop_value), .loop_set(ctl[LSET]),
      .loop_zero(ctl[LZERO]), .ram_wr(ram_wr), .ram_sel(ram_sel), .ram_addr(ram_addr),
      .ram_wdata(ram_wdata), .vec_ready(vec_ready), .vec_valid(vec_valid), .vec_out(vec_out),
      .out_enable(out_enable), .status(status), .cur_addr(cur_addr), .test_read(test_read));
   vec_sink sink (.core_clk(core_clk), .rst(rst), .hold(hold), .vec_valid(vec_valid),
      .vec_out(vec_out), .vec_ready(vec_ready), .got(got), .last_vec(last_vec));
   function automatic logic [31:0] lfsr(logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   function automatic logic [15:0] pat(int k, int a, int r);
      if (k == 0 || (k == 4 && r == 5)) return 16'h0000;
      if (k == 1) return 16'hFFFF;
      if (k == 2) return a[0] ? 16'hAAAA : 16'h5555;
      return seed[15:0];
   endfunction : pat
   function automatic logic pat_ok(int p, logic [NUM_PODS*WORD_W-1:0] v);
      if (p == 1) return v == {NUM_PODS{16'h5555}} || v == {NUM_PODS{16'hAAAA}};
      return $countones(v) == 1 || $countones(v) == NUM_PODS;
   endfunction : pat_ok
   task automatic chk(string nm, logic [95:0] seen, logic [95:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic clk(int n);
      repeat (n) @(posedge core_clk);
   endtask : clk
   task automatic pulse(int b);
      @(posedge core_clk);
      ctl[b] <= 1'b1;
      @(posedge core_clk);
      ctl[b] <= 1'b0;
   endtask : pulse
   task automatic wr(int r, int a, logic [15:0] d);
      @(posedge core_clk);
      img[r][a] = d;
      ram_wr <= 1'b1;
      ram_sel <= r[2:0];
      ram_addr <= addr_s'(a[7:0]);
      ram_wdata <= d;
      @(posedge core_clk);
      ram_wr <= 1'b0;
   endtask : wr
   task automatic settle();
      // Let the status of the last control pulse show before polling it
      clk(2);
      for (int i = 0; i < 3000 && status.running === 1'b1 && status.waiting !== 1'b1; i++)
         @(posedge core_clk);
      clk(2);
   endtask : settle
   task automatic run();
      pulse(HALT);
      pulse(LZERO);
      pulse(GO);
      settle();
   endtask : run
   task automatic final_report();
      if (failures == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : final_report
   always #20 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      seed <= lfsr(seed);
      hold <= stall_en & seed[3];
   end
   initial begin
      repeat (80000) @(posedge core_clk);
      failures++;
      final_report();
   end
   initial begin
      {core_clk, ctl, branch_event, loop_wr, ram_wr, hold, stall_en} = '0;
      {clk_src_sel, loop_sel, ram_sel, event_none, event_hit, ram_wdata} = '0;
      freq_mode = MODE_50;
      branch_pattern = BR_NEVER;
      test_pattern = PAT_RAM;
      {loop_value, ram_addr} = '0;
      rst = 1'b1;
      clk(6);
      rst <= 1'b0;
      clk(1);
      chk("reset state", {status, out_enable, cur_addr}, '0);
      for (int k = 0; k < 4; k++) begin
         for (int a = 0; a < 256; a++)
            for (int r = 0; r < NUM_RAMS; r++) wr(r, a, pat(k, a, r));
         pulse(LZERO);
         for (int a = 0; a < 256; a++) begin
            if (a > 0) pulse(STEP);
            clk(3);
            chk("step address", cur_addr, a[7:0]);
            for (int r = 0; r < NUM_RAMS; r++)
               chk("test read", test_read[16*r +: 16], img[r][a]);
         end
      end
      for (int i = 0; i < NUM_LOOPS; i++) begin
         @(posedge core_clk);
         lv[i] = seed[7:0];
         loop_wr <= 1'b1;
         loop_sel <= i[1:0];
         loop_value <= addr_s'(lv[i]);
      end
      @(posedge core_clk);
      loop_wr <= 1'b0;
      for (int i = 0; i < NUM_LOOPS; i++) begin
         loop_sel <= i[1:0];
         pulse(LSET);
         clk(3);
         chk("loop set", cur_addr, lv[i]);
         chk("loop word", test_read[15:0], img[0][lv[i]]);
         pulse(LZERO);
         clk(1);
         chk("loop zero", cur_addr, 8'h00);
      end
      for (int a = 0; a < 256; a++)
         for (int r = 0; r < NUM_RAMS; r++) wr(r, a, pat(4, a, r));
      for (int m = 0; m < 3; m++) begin
         freq_mode <= freq_mode_e'(m);
         clk_src_sel <= m[1:0];
         stall_en <= 1'b1;
         pulse(GO);
         clk(300);
         chk("nop running", {status.running, out_enable}, 2'b11);
         stall_en <= 1'b0;
         clk(20);
         dv = (m == 0) ? DIV_50 : (m == 1) ? DIV_100 : DIV_200;
         n0 = got;
         clk(100);
         chk("vector rate", (got - n0) + 4 >= 100 / dv && (got - n0) <= 100 / dv + 4, 1);
         pulse(HALT);
         clk(1);
         chk("stopped", {status.running, out_enable, status.by_stop}, 3'b001);
      end
      for (int p = 1; p < 3; p++) begin
         test_pattern <= pattern_e'(p);
         pulse(GO);
         clk(40);
         chk("test pattern", pat_ok(p, last_vec), 1);
         pulse(HALT);
      end
      test_pattern <= PAT_RAM;
      wr(5, 254, {OP_BREAK, 12'h000});
      run();
      chk("break stop", {status.running, status.by_break}, 2'b01);
      wr(5, 254, 16'h0000);
      wr(5, 48, {OP_BREAK, 12'h000});
      for (int e = 0; e < NUM_EVENTS; e++) begin
         wr(5, 16, {OP_WAIT, e[1:0], 10'h000});
         event_hit <= 4'hF;
         event_none <= 4'(1 << e);
         run();
         chk("no event", {status.waiting, status.by_break}, 2'b01);
         event_none <= 4'h0;
         run();
         chk("any event", {status.waiting, status.by_break}, 2'b10);
         pulse(CLR);
         settle();
         chk("wait clear", {status.waiting, status.by_break}, 2'b01);
      end
      wr(5, 17, {OP_WAIT, 12'h000});
      wr(5, 16, {OP_IF, 4'h0, 8'h40});
      wr(5, 64, {OP_BREAK, 12'h000});
      for (int b = 0; b < 3; b++) begin
         tk = (b == 1) || (b == 2 && seed[0]);
         branch_pattern <= branch_e'(b);
         branch_event <= seed[0];
         run();
         chk("if branch", {status.waiting, status.by_break}, tk ? 2'b01 : 2'b10);
      end
      pulse(GO);
      rst <= 1'b1;
      clk(2);
      chk("mid reset", {status, out_enable, cur_addr}, '0);
      rst <= 1'b0;
      clk(2);
      final_report();
   end
endmodule : testbench
`default_nettype wire
